// [design/sics_pkg.sv]
// Shared constants and types for the stack and interrupt cycle sequencer.
// Assumes one processor clock, one bus cycle per clock edge.
package sics_pkg;

  typedef enum logic [2:0] {
    RETURN_SUB,
    WAIT_FOR_INTERRUPT,
    MULTIPLY_OP,
    INTERRUPT_RETURN,
    SOFTWARE_TRAP
  } sics_op_e;

  typedef enum logic {
    SICS_ST_IDLE,
    SICS_ST_RUN
  } sics_state_e;

  // Cycle counts per instruction
  localparam logic [3:0]  SICS_CYC_RTS       = 4'h5;
  localparam logic [3:0]  SICS_CYC_WAIT      = 4'h9;
  localparam logic [3:0]  SICS_CYC_MUL       = 4'hA;
  localparam logic [3:0]  SICS_CYC_RTI       = 4'hA;
  localparam logic [3:0]  SICS_CYC_TRAP      = 4'hC;
  // Cycle positions
  localparam logic [3:0]  SICS_PUSH_FIRST    = 4'h3;
  localparam logic [3:0]  SICS_PUSH_LAST     = 4'h9;
  localparam logic [3:0]  SICS_TRAP_DUMMY    = 4'hA;
  localparam logic [3:0]  SICS_TRAP_VEC_HI   = 4'hB;
  localparam logic [3:0]  SICS_MUL_STEP_LAST = 4'h9;
  // Addresses
  localparam logic [15:0] SICS_ADDR_DUMMY    = 16'hFFFF;
  localparam logic [15:0] SICS_VEC_HI        = 16'hFFFA;
  localparam logic [15:0] SICS_VEC_LO        = 16'hFFFB;
  // Stack movements
  localparam logic [15:0] SICS_FRAME_SIZE    = 16'h0007;
  localparam logic [15:0] SICS_RTS_SIZE      = 16'h0002;
  // Reset values
  localparam logic [15:0] SICS_RST_WORD      = 16'h0000;
  localparam logic [7:0]  SICS_RST_BYTE      = 8'h00;

endpackage

// [design/sics_mul.sv]
// Shift-add 8x8 unsigned multiplier, one partial product per step.
// Assumes the caller loads once and then gives exactly eight steps.
module sics_mul
  import sics_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  // Control
  input  wire logic                 i_load,
  input  wire logic                 i_step,
  // Operands
  input  wire logic [WIDTH-1:0]     i_a,
  input  wire logic [WIDTH-1:0]     i_b,
  // Result
  output logic      [2*WIDTH-1:0]   o_prod
);

  if (WIDTH < 2) begin : g_width_check
    $error("sics_mul: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0]   mcand_reg;
  logic [2*WIDTH-1:0] prod_reg;
  logic [WIDTH:0]     sum;

  // Add multiplicand when low bit of multiplier set, then shift right
  always_comb begin
    sum = {1'b0, prod_reg[2*WIDTH-1:WIDTH]} + (prod_reg[0] ? {1'b0, mcand_reg} : '0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mcand_reg <= '0;
      prod_reg  <= '0;
    end else if (i_load) begin
      mcand_reg <= i_a;
      prod_reg  <= {{WIDTH{1'b0}}, i_b};
    end else if (i_step) begin
      prod_reg  <= {sum, prod_reg[WIDTH-1:1]};
    end
  end

  assign o_prod = prod_reg;

endmodule

// [design/sics_seq.sv]
// Bus cycle sequencer for five inherent stack and interrupt instructions.
// Assumes memory answers reads within the same cycle the address is shown.
// Overview of operation
// - return from subroutine: five reads, pulls return
// - wait for interrupt: nine cycles, seven writes
// - push PC, index, A, B, flags descending
// - multiply: ten cycles, eight dummies at FFFF
// - interrupt return pulls flags, B, A
// - interrupt return pulls index high then low
// - interrupt return pulls PC in cycles 9,10
// - trap: twelve cycles, pushes, dummy at SP-7
// - trap fetches handler from FFFA then FFFB
// - write line low on pushes, high otherwise
module sics_seq
  import sics_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Instruction request
  input  wire logic        i_start,
  input  wire sics_op_e    i_op,
  // Register file seed
  input  wire logic [15:0] i_pc,
  input  wire logic [15:0] i_sp,
  input  wire logic [15:0] i_ix,
  input  wire logic [7:0]  i_acca,
  input  wire logic [7:0]  i_accb,
  input  wire logic [7:0]  i_ccr,
  // Memory bus
  input  wire logic [7:0]  i_rdata,
  output logic      [15:0] o_addr,
  output logic             o_rw,
  output logic      [7:0]  o_wdata,
  output logic      [3:0]  o_cycle,
  // Status
  output logic             o_busy,
  output logic             o_done,
  // Register file result
  output logic      [15:0] o_pc,
  output logic      [15:0] o_sp,
  output logic      [15:0] o_ix,
  output logic      [7:0]  o_acca,
  output logic      [7:0]  o_accb,
  output logic      [7:0]  o_ccr
);

  typedef struct packed {
    sics_state_e st;
    sics_op_e    op;
    logic [3:0]  cyc;
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  wdata;
    logic        busy;
    logic        done;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] ix;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  c;
  } sics_state_s;

  sics_state_s r_reg;
  sics_state_s r_next;
  logic [15:0] prod;
  logic        mul_load, mul_step;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  function automatic logic [3:0] last_cyc(input sics_op_e op);
    case (op)
      RETURN_SUB:         last_cyc = SICS_CYC_RTS;
      WAIT_FOR_INTERRUPT: last_cyc = SICS_CYC_WAIT;
      MULTIPLY_OP:        last_cyc = SICS_CYC_MUL;
      INTERRUPT_RETURN:   last_cyc = SICS_CYC_RTI;
      default:            last_cyc = SICS_CYC_TRAP;
    endcase
  endfunction

  // Address, write line and write data of bus cycle n
  function automatic logic [24:0] bus_plan(input sics_op_e op, input logic [3:0] n,
                                           input logic [15:0] pc, sp, ix,
                                           input logic [7:0] a, b, c);
    logic [15:0] ad;
    logic        rw;
    logic [7:0]  d;
    logic [15:0] ret;
    ad  = SICS_ADDR_DUMMY;
    rw  = 1'b1;
    d   = SICS_RST_BYTE;
    ret = pc + 16'h0001;
    if (n == 4'h1) begin
      ad = pc;
    end else if (n == 4'h2) begin
      ad = ret;
    end else if (op == MULTIPLY_OP) begin
      ad = SICS_ADDR_DUMMY;
    end else if (op == RETURN_SUB || op == INTERRUPT_RETURN) begin
      ad = sp + 16'(n) - 16'(SICS_PUSH_FIRST);
    end else if (n <= SICS_PUSH_LAST) begin
      ad = sp - 16'(n - SICS_PUSH_FIRST);
      rw = 1'b0;
      case (n)
        4'h3:    d = ret[7:0];
        4'h4:    d = ret[15:8];
        4'h5:    d = ix[7:0];
        4'h6:    d = ix[15:8];
        4'h7:    d = a;
        4'h8:    d = b;
        default: d = c;
      endcase
    end else if (n == SICS_TRAP_DUMMY) begin
      ad = sp - SICS_FRAME_SIZE;
    end else if (n == SICS_TRAP_VEC_HI) begin
      ad = SICS_VEC_HI;
    end else begin
      ad = SICS_VEC_LO;
    end
    bus_plan = {ad, rw, d};
  endfunction

  always_comb begin
    r_next   = r_reg;
    r_next.done = 1'b0;
    mul_load = 1'b0;
    mul_step = 1'b0;
    case (r_reg.st)
      SICS_ST_IDLE: begin
        if (i_start) begin
          r_next.st   = SICS_ST_RUN;
          r_next.op   = i_op;
          r_next.cyc  = 4'h1;
          r_next.busy = 1'b1;
          {r_next.pc, r_next.sp, r_next.ix} = {i_pc, i_sp, i_ix};
          {r_next.a, r_next.b, r_next.c}    = {i_acca, i_accb, i_ccr};
          mul_load    = (i_op == MULTIPLY_OP);
          {r_next.addr, r_next.rw, r_next.wdata} =
            bus_plan(i_op, 4'h1, i_pc, i_sp, i_ix, i_acca, i_accb, i_ccr);
        end
      end
      SICS_ST_RUN: begin
        // Pulls from the stack, vector fetch and multiply steps
        case (r_reg.op)
          RETURN_SUB: begin
            if (r_reg.cyc == 4'h4) r_next.pc[15:8] = i_rdata;
            if (r_reg.cyc == 4'h5) r_next.pc[7:0] = i_rdata;
          end
          INTERRUPT_RETURN: begin
            if (r_reg.cyc == 4'h4) r_next.c = i_rdata;
            if (r_reg.cyc == 4'h5) r_next.b = i_rdata;
            if (r_reg.cyc == 4'h6) r_next.a = i_rdata;
            if (r_reg.cyc == 4'h7) r_next.ix[15:8] = i_rdata;
            if (r_reg.cyc == 4'h8) r_next.ix[7:0] = i_rdata;
            if (r_reg.cyc == 4'h9) r_next.pc[15:8] = i_rdata;
            if (r_reg.cyc == 4'hA) r_next.pc[7:0] = i_rdata;
          end
          SOFTWARE_TRAP: begin
            if (r_reg.cyc == SICS_TRAP_VEC_HI) r_next.pc[15:8] = i_rdata;
            if (r_reg.cyc == SICS_CYC_TRAP) r_next.pc[7:0] = i_rdata;
          end
          MULTIPLY_OP: begin
            mul_step = (r_reg.cyc >= 4'h2) && (r_reg.cyc <= SICS_MUL_STEP_LAST);
          end
          default: mul_step = 1'b0;
        endcase
        if (r_reg.cyc == last_cyc(r_reg.op)) begin
          r_next.st    = SICS_ST_IDLE;
          r_next.busy  = 1'b0;
          r_next.cyc   = 4'h0;
          r_next.addr  = SICS_ADDR_DUMMY;
          r_next.rw    = 1'b1;
          r_next.wdata = SICS_RST_BYTE;
          case (r_reg.op)
            RETURN_SUB:         r_next.sp = r_reg.sp + SICS_RTS_SIZE;
            INTERRUPT_RETURN:   r_next.sp = r_reg.sp + SICS_FRAME_SIZE;
            SOFTWARE_TRAP:      r_next.sp = r_reg.sp - SICS_FRAME_SIZE;
            WAIT_FOR_INTERRUPT: begin
              r_next.sp = r_reg.sp - SICS_FRAME_SIZE;
              r_next.pc = r_reg.pc + 16'h0001;
            end
            default: begin
              r_next.pc = r_reg.pc + 16'h0001;
              {r_next.a, r_next.b} = prod;
            end
          endcase
        end else begin
          r_next.cyc  = r_reg.cyc + 4'h1;
          r_next.done = (r_next.cyc == last_cyc(r_reg.op));
          {r_next.addr, r_next.rw, r_next.wdata} =
            bus_plan(r_reg.op, r_next.cyc, r_reg.pc, r_reg.sp, r_reg.ix,
                     r_reg.a, r_reg.b, r_reg.c);
        end
      end
      default: r_next.st = SICS_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r_reg       <= '0;
      r_reg.addr  <= SICS_ADDR_DUMMY;
      r_reg.rw    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  sics_mul #(
    .WIDTH (8)
  ) u_mul (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_load (mul_load),
    .i_step (mul_step),
    .i_a    (i_acca),
    .i_b    (i_accb),
    .o_prod (prod)
  );

  assign o_addr  = r_reg.addr;
  assign o_rw    = r_reg.rw;
  assign o_wdata = r_reg.wdata;
  assign o_cycle = r_reg.cyc;
  assign o_busy  = r_reg.busy;
  assign o_done  = r_reg.done;
  assign o_pc    = r_reg.pc;
  assign o_sp    = r_reg.sp;
  assign o_ix    = r_reg.ix;
  assign o_acca  = r_reg.a;
  assign o_accb  = r_reg.b;
  assign o_ccr   = r_reg.c;

  // Checks
  logic take, rti_run, trap_run, stk_run;
  assign take     = i_start && !r_reg.busy;
  assign rti_run  = o_busy && r_reg.op == INTERRUPT_RETURN;
  assign trap_run = o_busy && r_reg.op == SOFTWARE_TRAP;
  assign stk_run  = o_busy && (r_reg.op == WAIT_FOR_INTERRUPT || r_reg.op == SOFTWARE_TRAP);

  property p_rts_len;
    take && i_op == RETURN_SUB |-> ##5 (o_done && o_cycle == 4'h5) ##1 !o_busy;
  endproperty
  a_rts_len: assert property (p_rts_len) else $error("return length wrong");
  property p_wait_len;
    take && i_op == WAIT_FOR_INTERRUPT |-> ##1 o_rw [*2] ##1 !o_rw [*7] ##0 o_done;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait sequence wrong");
  property p_push;
    stk_run && o_cycle == 4'h7 |-> o_addr == o_sp - 16'h0004 && o_wdata == o_acca;
  endproperty
  a_push: assert property (p_push) else $error("push slot wrong");
  property p_mul;
    take && i_op == MULTIPLY_OP |-> ##3 (o_addr == 16'hFFFF && o_rw) [*8] ##0 o_done;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply dummies wrong");
  property p_rti_pull;
    rti_run && o_cycle >= 4'h3 |-> o_rw && o_addr == o_sp + 16'(o_cycle) - 16'h0003;
  endproperty
  a_rti_pull: assert property (p_rti_pull) else $error("pull address wrong");
  property p_rti_ix;
    rti_run && o_cycle == 4'h8 |=> o_ix == {$past(r_reg.ix[15:8]), $past(i_rdata)};
  endproperty
  a_rti_ix: assert property (p_rti_ix) else $error("index pull wrong");
  property p_rti_pc;
    rti_run && o_cycle == 4'h9 |=> o_addr == o_sp + 16'h0007 && o_done &&
      o_pc[15:8] == $past(i_rdata);
  endproperty
  a_rti_pc: assert property (p_rti_pc) else $error("pc pull wrong");
  property p_trap_dummy;
    trap_run && o_cycle == 4'hA |-> o_rw && o_addr == o_sp - 16'h0007;
  endproperty
  a_trap_dummy: assert property (p_trap_dummy) else $error("trap dummy wrong");
  property p_trap_vec;
    trap_run && o_cycle == 4'hB |-> o_addr == 16'hFFFA ##1 (o_addr == 16'hFFFB && o_done);
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("vector fetch wrong");
  property p_rw;
    o_busy && !o_rw |-> stk_run && o_cycle >= 4'h3 && o_cycle <= 4'h9;
  endproperty
  a_rw: assert property (p_rw) else $error("write line wrong");
  property p_sp;
    o_done && r_reg.op == SOFTWARE_TRAP |=> o_sp == $past(o_sp) - 16'h0007;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer wrong");
  property p_prod;
    o_done && r_reg.op == MULTIPLY_OP |=>
      {o_acca, o_accb} == 16'($past(o_acca)) * 16'($past(o_accb));
  endproperty
  a_prod: assert property (p_prod) else $error("product wrong");
  c_rti: cover property (o_done && r_reg.op == INTERRUPT_RETURN);
  c_trap: cover property (o_done && r_reg.op == SOFTWARE_TRAP);
  c_mul: cover property (o_done && r_reg.op == MULTIPLY_OP);

endmodule

// [testbench/sics_mem_model.sv]
// External memory model on the processor bus of the sequencer.
// Assumes reads are answered in the same cycle the address is shown.
module sics_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Bus from the sequencer
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rw,
  input  wire logic [7:0]  i_wdata,
  // Read data back
  output logic      [7:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [0:65535];
  logic [7:0] last_rd;

  initial begin
    last_rd = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
  end

  // Bus not driven by memory shows the inverse of the last byte
  assign o_rdata = i_rw ? mem[i_addr] : ~last_rd;

  always @(posedge i_clk) begin
    if (i_rw) begin
      last_rd <= mem[i_addr];
    end else begin
      mem[i_addr] <= i_wdata;
    end
  end

  task automatic poke(input logic [15:0] ad, input logic [7:0] d);
    mem[ad] = d;
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the stack and interrupt cycle sequencer.
// Assumes the memory model answers reads combinationally.
module testbench
  import sics_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  sics_op_e    op = RETURN_SUB;
  logic [15:0] pc = 16'h0000, sp = 16'h0000, ix = 16'h0000;
  logic [7:0]  a = 8'h00, b = 8'h00, c = 8'h00;
  logic [7:0]  rdata;
  logic [15:0] addr, opc, osp, oix;
  logic        rw, busy, done;
  logic [7:0]  wd, oa, ob, occ;
  logic [3:0]  cyc_n;
  logic [15:0] ea [1:12];
  logic        ew [1:12];
  logic [7:0]  ed [1:12];
  int          bad_count = 0;
  int          n_checks = 0;

  always #4 clk = ~clk;

  sics_seq dut (.i_clk(clk), .i_nrst(nrst), .i_start(start), .i_op(op), .i_pc(pc), .i_sp(sp),
    .i_ix(ix), .i_acca(a), .i_accb(b), .i_ccr(c), .i_rdata(rdata), .o_addr(addr), .o_rw(rw),
    .o_wdata(wd), .o_cycle(cyc_n), .o_busy(busy), .o_done(done), .o_pc(opc), .o_sp(osp),
    .o_ix(oix), .o_acca(oa), .o_accb(ob), .o_ccr(occ));

  sics_mem_model mem (.i_clk(clk), .i_addr(addr), .i_rw(rw), .i_wdata(wd), .o_rdata(rdata));

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic seed(input logic [15:0] p, s, x, input logic [7:0] va, vb, vc);
    {pc, sp, ix, a, b, c} = {p, s, x, va, vb, vc};
  endtask

  task automatic cyc(input int k, input logic [15:0] ad, input logic w, input logic [7:0] d);
    ea[k] = ad;
    ew[k] = w;
    ed[k] = d;
  endtask

  task automatic head(input logic [15:0] p);
    cyc(1, p, 1'b1, 8'h00);
    cyc(2, p + 16'h0001, 1'b1, 8'h00);
  endtask

  // Seven descending pushes in cycles 3 to 9
  task automatic push7(input logic [15:0] s, input logic [15:0] r);
    logic [7:0] v [0:6];
    v = '{r[7:0], r[15:8], ix[7:0], ix[15:8], a, b, c};
    for (int k = 0; k < 7; k++) begin
      cyc(k + 3, s - 16'(k), 1'b0, v[k]);
    end
  endtask

  task automatic launch(input sics_op_e o);
    start = 1'b1;
    op = o;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask

  // Compares every bus cycle; rk raises a request while busy
  task automatic walk(input int n, input int rk);
    for (int k = 1; k <= n; k++) begin
      chk(addr, ea[k], "address");
      chk({15'h0, rw}, {15'h0, ew[k]}, "rw");
      chk({8'h00, wd}, {8'h00, ed[k]}, "write data");
      chk({12'h0, cyc_n}, 16'(k), "cycle");
      chk({15'h0, busy}, 16'h0001, "busy");
      chk({15'h0, done}, {15'h0, k == n}, "done");
      start = (k == rk);
      @(posedge clk);
      #1;
    end
    chk({14'h0, busy, done}, 16'h0000, "idle after end");
  endtask

  task automatic chk_idle();
    chk(addr, 16'hFFFF, "idle address");
    chk({11'h0, rw, cyc_n}, 16'h0010, "idle rw and cycle");
    chk({15'h0, busy}, 16'h0000, "idle busy");
    chk(osp, 16'h0000, "sp reset");
  endtask

  task automatic t_rts();
    seed(16'h2000, 16'h0100, 16'h0000, 8'h00, 8'h00, 8'h00);
    mem.poke(16'h0101, 8'h34);
    mem.poke(16'h0102, 8'h56);
    head(16'h2000);
    for (int k = 3; k <= 5; k++) begin
      cyc(k, 16'h00FD + 16'(k), 1'b1, 8'h00);
    end
    launch(RETURN_SUB);
    walk(5, 0);
    chk(opc, 16'h3456, "pc");
    chk(osp, 16'h0102, "sp");
  endtask

  task automatic t_wait();
    seed(16'h1234, 16'h01FF, 16'hBEEF, 8'h11, 8'h22, 8'hC3);
    head(16'h1234);
    push7(16'h01FF, 16'h1235);
    launch(WAIT_FOR_INTERRUPT);
    walk(9, 0);
    chk(osp, 16'h01F8, "sp");
    chk(opc, 16'h1235, "pc after wait");
  endtask

  task automatic t_mul(input logic [7:0] x, input logic [7:0] y, input int rk);
    seed(16'h3000, 16'h0400, 16'h0000, x, y, 8'h00);
    head(16'h3000);
    for (int k = 3; k <= 10; k++) begin
      cyc(k, 16'hFFFF, 1'b1, 8'h00);
    end
    launch(MULTIPLY_OP);
    walk(10, rk);
    chk({oa, ob}, 16'(x) * 16'(y), "product");
    chk(opc, 16'h3001, "pc after multiply");
  endtask

  task automatic t_rti();
    logic [7:0] v [0:6];
    v = '{8'hCC, 8'hBB, 8'hAA, 8'h12, 8'h34, 8'h56, 8'h78};
    seed(16'h5000, 16'h0200, 16'h0000, 8'h00, 8'h00, 8'h00);
    head(16'h5000);
    cyc(3, 16'h0200, 1'b1, 8'h00);
    for (int k = 0; k < 7; k++) begin
      mem.poke(16'h0201 + 16'(k), v[k]);
      cyc(k + 4, 16'h0201 + 16'(k), 1'b1, 8'h00);
    end
    launch(INTERRUPT_RETURN);
    walk(10, 0);
    chk({occ, ob}, 16'hCCBB, "flags and B");
    chk({8'h00, oa}, 16'h00AA, "A");
    chk(oix, 16'h1234, "index");
    chk(opc, 16'h5678, "pc");
    chk(osp, 16'h0207, "sp");
  endtask

  task automatic t_swi();
    seed(16'h4000, 16'h0300, 16'hCAFE, 8'h44, 8'h55, 8'h66);
    mem.poke(16'hFFFA, 8'h9A);
    mem.poke(16'hFFFB, 8'hBC);
    head(16'h4000);
    push7(16'h0300, 16'h4001);
    cyc(10, 16'h02F9, 1'b1, 8'h00);
    cyc(11, 16'hFFFA, 1'b1, 8'h00);
    cyc(12, 16'hFFFB, 1'b1, 8'h00);
    launch(SOFTWARE_TRAP);
    walk(12, 0);
    chk(opc, 16'h9ABC, "vector");
    chk(osp, 16'h02F9, "sp");
  endtask

  task automatic t_mid_reset();
    launch(SOFTWARE_TRAP);
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b0;
    @(posedge clk);
    #1;
    nrst = 1'b1;
    chk_idle();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk_idle();
    t_rts();
    t_wait();
    t_mul(8'hFF, 8'hFF, 5);
    t_mul(8'h0D, 8'h0B, 0);
    t_rti();
    t_swi();
    t_mid_reset();
    t_rts();
    final_report();
  end
endmodule
